// ==== dpg_gateway.v ====
// Operation
// (RL1) sixty-six network unit groups, 4000 registers each
// (RL2) unit id equals serial slave address
// (RL3) both sides share each register location
// (RL4) auto address on: use dhcp lease
// (RL5) auto address off: use static addresses
// (RL6) addresses held as 32 bits, four bytes
// (RL7) store sixteen character port name
// (RL8) name readable in unit 65 from 2002
// (RL9) units 1-32 network writes, serial reads
// (RL10) units 33-64 serial writes, network reads
// (RL11) unit 66 read/write from both sides
// (RL12) serial master uses codes 3, 6, 16
// (RL13) unit 65 network read-only, writes get exception
`timescale 1ns/1ps
`include "dpg_regs.vh"

module dpg_gateway #(
   parameter UNITS = `DPG_UNITS,
   parameter REGS  = `DPG_REGS_PER_UNIT,
   parameter IW    = `DPG_IDX_W
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        net_req,
   input  wire        net_wr,
   input  wire [6:0]  net_unit,
   input  wire [11:0] net_addr,
   input  wire [15:0] net_wdata,
   output reg         net_ack,
   output reg  [15:0] net_rdata,
   output reg  [7:0]  net_exc,
   input  wire        ser_req,
   input  wire        ser_wr,
   input  wire [6:0]  ser_unit,
   input  wire [11:0] ser_addr,
   input  wire [15:0] ser_wdata,
   output reg         ser_ack,
   output reg  [15:0] ser_rdata,
   output reg  [7:0]  ser_exc,
   input  wire        lease_valid,
   input  wire [31:0] lease_ip,
   input  wire [31:0] lease_mask,
   input  wire [31:0] lease_gw,
   output reg         dhcp_request,
   output reg  [31:0] active_ip,
   output reg  [31:0] active_mask,
   output reg  [31:0] active_gw
);

   // control word value out of reset, one bit of it is used
   localparam [31:0] RST_CTRL = `DPG_RST_CTRL;
   // configuration state written over apb
   reg         auto_address_enable_ff;  // dhcp on when set
   reg  [31:0] static_ip_ff;            // four bytes, first octet high
   reg  [31:0] static_mask_ff;
   reg  [31:0] static_gw_ff;
   reg  [127:0] name_ff;                // char i in bits 8i+7:8i

   // dhcp lease capture, valid flag comes from another domain
   reg         lease_s1_ff;             // first stage, read only by s2
   reg         lease_s2_ff;
   reg         lease_ok_ff;             // lease held and still valid
   reg  [31:0] lease_ip_ff;
   reg  [31:0] lease_mask_ff;
   reg  [31:0] lease_gw_ff;

   // two-stage sync of the lease flag before anything looks at it
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lease_s1_ff <= 1'b0;
         lease_s2_ff <= 1'b0;
      end else begin
         lease_s1_ff <= lease_valid;
         lease_s2_ff <= lease_s1_ff;
      end
   end

   // lease words are sampled only once the flag has settled, so
   // the source must hold them stable while the flag is high
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lease_ok_ff   <= 1'b0;
         lease_ip_ff   <= `DPG_RST_ADDR;
         lease_mask_ff <= `DPG_RST_ADDR;
         lease_gw_ff   <= `DPG_RST_ADDR;
      end else begin
         lease_ok_ff <= lease_s2_ff;
         if (lease_s2_ff) begin
            lease_ip_ff   <= lease_ip;   // RL6
            lease_mask_ff <= lease_mask;
            lease_gw_ff   <= lease_gw;
         end
      end
   end

   // pick the address set the network port runs with
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dhcp_request <= 1'b0;
         active_ip    <= `DPG_RST_ADDR;
         active_mask  <= `DPG_RST_ADDR;
         active_gw    <= `DPG_RST_ADDR;
      end else if (auto_address_enable_ff) begin
         dhcp_request <= 1'b1;             // RL4
         // until a lease arrives the port has no address
         active_ip    <= lease_ok_ff ? lease_ip_ff : `DPG_RST_ADDR;
         active_mask  <= lease_ok_ff ? lease_mask_ff : `DPG_RST_ADDR;
         active_gw    <= lease_ok_ff ? lease_gw_ff : `DPG_RST_ADDR;
      end else begin
         dhcp_request <= 1'b0;
         active_ip    <= static_ip_ff;     // RL5
         active_mask  <= static_mask_ff;
         active_gw    <= static_gw_ff;
      end
   end

   // ---------------- apb slave ----------------
   wire        apb_setup = psel & ~penable;
   wire        apb_wr    = psel & penable & pwrite & pready;
   reg  [31:0] nxt_prdata;
   reg         nxt_err;

   // read mux and decode, evaluated in the setup cycle
   always @* begin
      nxt_prdata = 32'h0000_0000;
      nxt_err    = 1'b0;
      case (paddr)
         `DPG_OFS_CTRL:  nxt_prdata = {31'h0, auto_address_enable_ff};
         `DPG_OFS_SIP:   nxt_prdata = static_ip_ff;
         `DPG_OFS_SMASK: nxt_prdata = static_mask_ff;
         `DPG_OFS_SGW:   nxt_prdata = static_gw_ff;
         `DPG_OFS_NAME0: nxt_prdata = name_ff[31:0];
         `DPG_OFS_NAME1: nxt_prdata = name_ff[63:32];
         `DPG_OFS_NAME2: nxt_prdata = name_ff[95:64];
         `DPG_OFS_NAME3: nxt_prdata = name_ff[127:96];
         `DPG_OFS_AIP:   nxt_prdata = active_ip;
         `DPG_OFS_AMASK: nxt_prdata = active_mask;
         `DPG_OFS_AGW:   nxt_prdata = active_gw;
         `DPG_OFS_STAT:  nxt_prdata = {30'h0, dhcp_request, lease_ok_ff};
         default:        nxt_err    = 1'b1;  // unmapped
      endcase
   end

   // one wait-free access phase; data latched in setup
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= apb_setup;
         if (apb_setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            // status words are read-only, writing them is an error
            pslverr <= nxt_err | (pwrite & (paddr >= `DPG_OFS_AIP));
         end
      end
   end

   // register writes take effect at the access edge
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         auto_address_enable_ff <= RST_CTRL[`DPG_CTRL_AUTO];
         static_ip_ff           <= `DPG_RST_ADDR;
         static_mask_ff         <= `DPG_RST_ADDR;
         static_gw_ff           <= `DPG_RST_ADDR;
         name_ff                <= 128'h0;
      end else if (apb_wr) begin
         case (paddr)
            `DPG_OFS_CTRL:  auto_address_enable_ff <= pwdata[`DPG_CTRL_AUTO];
            `DPG_OFS_SIP:   static_ip_ff   <= pwdata;   // RL6
            `DPG_OFS_SMASK: static_mask_ff <= pwdata;
            `DPG_OFS_SGW:   static_gw_ff   <= pwdata;
            `DPG_OFS_NAME0: name_ff[31:0]   <= pwdata;  // RL7
            `DPG_OFS_NAME1: name_ff[63:32]  <= pwdata;
            `DPG_OFS_NAME2: name_ff[95:64]  <= pwdata;
            `DPG_OFS_NAME3: name_ff[127:96] <= pwdata;
            default: ;
         endcase
      end
   end

   // ---------------- shared store access ----------------
   // unit and register numbers start at one on both sides
   function [IW-1:0] dpg_index;
      input [6:0]  unit;
      input [11:0] addr;
      reg   [31:0] full;
      begin
         full = (unit - 32'h1) * REGS + (addr - 32'h1);
         dpg_index = full[IW-1:0];
      end
   endfunction

   wire net_range = (net_unit != 7'h0) && (net_unit <= UNITS) &&
                    (net_addr != 12'h0) && (net_addr <= REGS); // RL1
   wire ser_range = (ser_unit != 7'h0) && (ser_unit <= UNITS) &&
                    (ser_addr != 12'h0) && (ser_addr <= REGS);

   // network may write only its own units and the common unit
   wire net_wr_ok = (net_unit <= `DPG_NET_LAST) ||    // RL9
                    (net_unit == `DPG_BOTH_UNIT);      // RL11
   // serial may write everything except the network units
   wire ser_wr_ok = (ser_unit >= `DPG_SER_FIRST);      // RL10 RL13

   wire net_go = net_req & net_range & (~net_wr | net_wr_ok);
   wire ser_go = ser_req & ser_range & (~ser_wr | ser_wr_ok);

   // same index formula on both sides so ids meet at one word
   wire [IW-1:0] net_idx = dpg_index(net_unit, net_addr);  // RL2
   wire [IW-1:0] ser_idx = dpg_index(ser_unit, ser_addr);  // RL2
   wire [15:0]   net_rd;
   wire [15:0]   ser_rd;

   dpg_store #(
      .DEPTH (UNITS * REGS),
      .IW    (IW)
   ) u_store (
      .clk     (clk),
      .net_we  (net_go & net_wr),
      .net_idx (net_idx),
      .net_wd  (net_wdata),
      .net_rd  (net_rd),
      .ser_we  (ser_go & ser_wr),
      .ser_idx (ser_idx),
      .ser_wd  (ser_wdata),
      .ser_rd  (ser_rd)
   );

   // name window overlays the stored words on network reads
   wire        net_name = (net_unit == `DPG_NAME_UNIT) &&
                          (net_addr >= `DPG_NAME_FIRST) &&
                          (net_addr <= `DPG_NAME_LAST);
   wire [11:0] name_off = net_addr - `DPG_NAME_FIRST;
   wire [6:0]  name_bit = {name_off[2:0], 4'h0};
   wire [15:0] name_pair = name_ff[name_bit +: 16];
   // first character of each pair goes in the high byte
   wire [15:0] name_word = {name_pair[7:0], name_pair[15:8]};

   // network answer, one cycle after the request
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         net_ack   <= 1'b0;
         net_rdata <= 16'h0000;
         net_exc   <= `DPG_EXC_NONE;
      end else begin
         net_ack <= net_req;
         if (net_req) begin
            if (!net_range) begin
               net_rdata <= 16'h0000;
               net_exc   <= `DPG_EXC_ADDR;
            end else if (net_wr && !net_wr_ok) begin
               net_rdata <= 16'h0000;
               net_exc   <= `DPG_EXC_FUNC;     // RL13
            end else begin
               // a write echoes the value now held
               net_rdata <= net_wr ? net_wdata :
                            (net_name ? name_word : net_rd); // RL8
               net_exc   <= `DPG_EXC_NONE;
            end
         end
      end
   end

   // serial answer; request codes are decoded by the serial master
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ser_ack   <= 1'b0;
         ser_rdata <= 16'h0000;
         ser_exc   <= `DPG_EXC_NONE;
      end else begin
         ser_ack <= ser_req;
         if (ser_req) begin
            if (!ser_range) begin
               ser_rdata <= 16'h0000;
               ser_exc   <= `DPG_EXC_ADDR;
            end else if (ser_wr && !ser_wr_ok) begin
               ser_rdata <= 16'h0000;
               ser_exc   <= `DPG_EXC_FUNC;     // RL9
            end else begin
               ser_rdata <= ser_wr ? ser_wdata : ser_rd;
               ser_exc   <= `DPG_EXC_NONE;
            end
         end
      end
   end

endmodule

// ==== dpg_regs.vh ====
`ifndef DPG_REGS_VH
`define DPG_REGS_VH

// shared store geometry
`define DPG_UNITS          66
`define DPG_REGS_PER_UNIT  4000
`define DPG_IDX_W          19

// unit group boundaries
`define DPG_NET_LAST       7'h20
`define DPG_SER_FIRST      7'h21
`define DPG_SER_LAST       7'h40
`define DPG_NAME_UNIT      7'h41
`define DPG_BOTH_UNIT      7'h42

// port name window inside the name unit
`define DPG_NAME_FIRST     12'h7D2
`define DPG_NAME_LAST      12'h7D9
`define DPG_NAME_CHARS     16

// exception codes returned on a refused access
`define DPG_EXC_NONE       8'h00
`define DPG_EXC_FUNC       8'h01
`define DPG_EXC_ADDR       8'h02

// apb register byte offsets
`define DPG_OFS_CTRL       12'h000
`define DPG_OFS_SIP        12'h004
`define DPG_OFS_SMASK      12'h008
`define DPG_OFS_SGW        12'h00C
`define DPG_OFS_NAME0      12'h010
`define DPG_OFS_NAME1      12'h014
`define DPG_OFS_NAME2      12'h018
`define DPG_OFS_NAME3      12'h01C
`define DPG_OFS_AIP        12'h020
`define DPG_OFS_AMASK      12'h024
`define DPG_OFS_AGW        12'h028
`define DPG_OFS_STAT       12'h02C

// field positions and reset values
`define DPG_CTRL_AUTO      0
`define DPG_STAT_LEASE     0
`define DPG_STAT_AUTO      1
`define DPG_RST_CTRL       32'h0000_0000
`define DPG_RST_ADDR       32'h0000_0000

`endif

// ==== dpg_store.v ====
`timescale 1ns/1ps
`include "dpg_regs.vh"

// shared holding-register array, one write and one read port per side
module dpg_store #(
   parameter DEPTH = `DPG_UNITS * `DPG_REGS_PER_UNIT,
   parameter IW    = `DPG_IDX_W
) (
   input  wire          clk,
   input  wire          net_we,
   input  wire [IW-1:0] net_idx,
   input  wire [15:0]   net_wd,
   output wire [15:0]   net_rd,
   input  wire          ser_we,
   input  wire [IW-1:0] ser_idx,
   input  wire [15:0]   ser_wd,
   output wire [15:0]   ser_rd
);

   reg [15:0] mem_ff [0:DEPTH-1];   // data only, no reset needed

   // both sides read one common location per index
   assign net_rd = mem_ff[net_idx]; // RL3
   assign ser_rd = mem_ff[ser_idx]; // RL3

   // serial write first so a same-cycle network write wins
   always @(posedge clk) begin
      if (ser_we) begin
         mem_ff[ser_idx] <= ser_wd;
      end
      if (net_we) begin
         mem_ff[net_idx] <= net_wd;
      end
   end

endmodule

// ==== dpg_gateway_checker.sv ====
`timescale 1ns/1ps
// watches the gateway ports for answer timing and access refusals
module dpg_gateway_checker (
   input wire        clk,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        pready,
   input wire        pslverr,
   input wire        net_req,
   input wire        net_wr,
   input wire [6:0]  net_unit,
   input wire [11:0] net_addr,
   input wire        net_ack,
   input wire [7:0]  net_exc,
   input wire        ser_req,
   input wire        ser_wr,
   input wire [6:0]  ser_unit,
   input wire [11:0] ser_addr,
   input wire        ser_ack,
   input wire [7:0]  ser_exc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // request lies inside the 66 x 4000 store
   wire nok = net_unit != 7'h00 && net_unit <= 7'h42 &&
              net_addr != 12'h000 && net_addr <= 12'hFA0;
   wire sok = ser_unit != 7'h00 && ser_unit <= 7'h42 &&
              ser_addr != 12'h000 && ser_addr <= 12'hFA0;
   chk_net_answer: assert property (net_req |=> net_ack)
      else $error("network answer missing");
   chk_ser_answer: assert property (ser_req |=> ser_ack)
      else $error("serial answer missing");
   chk_net_refuse: assert property (net_req && net_wr && nok &&
      net_unit >= 7'h21 && net_unit <= 7'h41 |=> net_exc == 8'h01)
      else $error("network write to read-only unit taken");
   chk_ser_refuse: assert property (ser_req && ser_wr && sok &&
      ser_unit <= 7'h20 |=> ser_exc == 8'h01)
      else $error("serial write to read-only unit taken");
   chk_net_range: assert property (net_req && !nok |=> net_exc == 8'h02)
      else $error("network range fault not flagged");
   chk_ser_range: assert property (ser_req && !sok |=> ser_exc == 8'h02)
      else $error("serial range fault not flagged");
   chk_both_open: assert property (net_req && nok &&
      net_unit == 7'h42 |=> net_exc == 8'h00)
      else $error("shared unit refused");
   chk_addr_locked: assert property (psel && !penable && pwrite &&
      paddr >= 12'h020 && paddr <= 12'h02C |=> pready && pslverr)
      else $error("write to active address accepted");
   cover property (net_req && net_unit == 7'h41 && net_addr == 12'h7D2);
   cover property (ser_req && ser_wr && ser_unit == 7'h42);
   cover property (psel && penable && pslverr);
endmodule

bind dpg_gateway dpg_gateway_checker u_dpg_gateway_checker (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .net_req(net_req), .net_wr(net_wr), .net_unit(net_unit),
   .net_addr(net_addr), .net_ack(net_ack), .net_exc(net_exc),
   .ser_req(ser_req), .ser_wr(ser_wr), .ser_unit(ser_unit),
   .ser_addr(ser_addr), .ser_ack(ser_ack), .ser_exc(ser_exc));

// ==== dpg_lease_model.sv ====
`timescale 1ns/1ps
// dhcp side: grants a lease some cycles after the request goes up
module dpg_lease_model #(
   parameter [31:0] IP   = 32'h0000_0001,
   parameter [31:0] MASK = 32'h0000_0002,
   parameter [31:0] GW   = 32'h0000_0003,
   parameter        DLY  = 6
) (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        dhcp_request,
   output wire        lease_valid,
   output wire [31:0] lease_ip,
   output wire [31:0] lease_mask,
   output wire [31:0] lease_gw
);
   reg         valid_ff; // lease held
   integer     cnt_ff;   // cycles since request
   // lease follows the request after a server delay
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         valid_ff <= 1'b0;
         cnt_ff   <= 0;
      end else if (!dhcp_request) begin
         valid_ff <= 1'b0;
         cnt_ff   <= 0;
      end else if (cnt_ff < DLY) begin
         cnt_ff <= cnt_ff + 1;
      end else begin
         valid_ff <= 1'b1;
      end
   end
   // no lease: values are junk so stale data never looks right
   assign lease_valid = valid_ff;
   assign lease_ip    = valid_ff ? IP : ~IP;
   assign lease_mask  = valid_ff ? MASK : ~MASK;
   assign lease_gw    = valid_ff ? GW : ~GW;
endmodule

// ==== dpg_gateway_bench.sv ====
`timescale 1ns/1ps
module dpg_gateway_bench;
   localparam [31:0] L_IP = 32'h0A00_0107, L_MK = 32'hFFFF_0000;
   localparam [31:0] L_GW = 32'h0A00_0001;
   logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lip, lmk, lgw, aip, amk, agw, r, ip, mk, gw;
   logic        rq[2], wr[2], ack[2], lv, dreq, e;
   logic [6:0]  un[2];
   logic [11:0] ad[2];
   logic [15:0] wd[2], rd[2];
   logic [7:0]  ex[2], nm[16];
   int          n_errors, check_count, cyc, t;
   int unsigned mem[int];  // behavioural store, key unit*4096+addr
   int          aset[5] = '{0, 1, 2, 4000, 4001}; // edge addresses
   dpg_gateway u_dpg_gateway (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .net_req(rq[0]), .net_wr(wr[0]), .net_unit(un[0]), .net_addr(ad[0]),
      .net_wdata(wd[0]), .net_ack(ack[0]), .net_rdata(rd[0]),
      .net_exc(ex[0]), .ser_req(rq[1]), .ser_wr(wr[1]), .ser_unit(un[1]),
      .ser_addr(ad[1]), .ser_wdata(wd[1]), .ser_ack(ack[1]),
      .ser_rdata(rd[1]), .ser_exc(ex[1]), .lease_valid(lv),
      .lease_ip(lip), .lease_mask(lmk), .lease_gw(lgw),
      .dhcp_request(dreq), .active_ip(aip), .active_mask(amk),
      .active_gw(agw));
   dpg_lease_model #(.IP(L_IP), .MASK(L_MK), .GW(L_GW)) u_dpg_lease_model (
      .clk(clk), .sys_rst(sys_rst), .dhcp_request(dreq), .lease_valid(lv),
      .lease_ip(lip), .lease_mask(lmk), .lease_gw(lgw));
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task conclude();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task cmp_val(string what, logic [31:0] x, logic [31:0] g);
      check_count++;
      if (g !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, x, g);
      end
   endtask
   task cmp_exc(string what, logic [7:0] x, logic [7:0] g);
      check_count++;
      if (g !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, x, g);
      end
   endtask
   // one apb transfer; waits for pready under a bound
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (pready !== 1'b1) begin
         n_errors++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // one register request on side s, checked against the model
   task req(int s, logic w, logic [6:0] u, logic [11:0] a, logic [15:0] d);
      int k;
      logic [7:0] xe;
      @(posedge clk);
      rq[s] <= 1; wr[s] <= w; un[s] <= u; ad[s] <= a; wd[s] <= d;
      @(posedge clk);
      rq[s] <= 0;
      wd[s] <= ~d; // released data is junk
      #1;
      k = u * 4096 + a;
      xe = (u == 0 || u > 66 || a == 0 || a > 4000) ? 2 :
           (w && (s == 0 ? (u > 32 && u < 66) : u < 33)) ? 1 : 0;
      cmp_val("ack", 1, ack[s]);
      cmp_exc("exc", xe, ex[s]);
      if (xe == 0) begin
         if (w) begin
            mem[k] = d;
            cmp_val("echo", d, rd[s]);
         end else if (s == 0 && u == 65 && a >= 2002 && a <= 2009)
            cmp_val("name", {nm[2*(a-2002)], nm[2*(a-2002)+1]}, rd[s]);
         else if (mem.exists(k))
            cmp_val("rdata", mem[k], rd[s]);
      end
   endtask
   initial begin
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      for (int i = 0; i < 2; i++) begin
         rq[i] = 0; wr[i] = 0; un[i] = 0; ad[i] = 0; wd[i] = 0;
      end
      sys_rst = 1; cyc = 0; n_errors = 0; check_count = 0;
      void'($urandom(98773));
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      // static addressing and register access kinds
      apb(0, 12'h000, 0);
      cmp_val("ctrl reset", 0, r);
      ip = $urandom; mk = $urandom; gw = $urandom;
      apb(1, 12'h004, ip);
      apb(1, 12'h008, mk);
      apb(1, 12'h00C, gw);
      repeat (3) @(posedge clk);
      cmp_val("ip", ip, aip);
      cmp_val("mask", mk, amk);
      cmp_val("gw", gw, agw);
      apb(0, 12'h020, 0);
      cmp_val("active rd", ip, r);
      apb(1, 12'h020, 0);
      cmp_val("ro err", 1, e);
      apb(0, 12'h040, 0);
      cmp_val("unmapped", 1, e);
      $display("test static done");
      // automatic addressing from the lease
      apb(1, 12'h000, 1);
      t = 0;
      while (aip !== L_IP && t < 100) begin
         @(posedge clk);
         t++;
      end
      cmp_val("dreq", 1, dreq);
      cmp_val("lease ip", L_IP, aip);
      cmp_val("lease mask", L_MK, amk);
      cmp_val("lease gw", L_GW, agw);
      apb(0, 12'h02C, 0);
      cmp_val("stat", 3, r);
      apb(1, 12'h000, 0);
      repeat (3) @(posedge clk);
      cmp_val("back static", ip, aip);
      $display("test auto done");
      // port name, char i at byte i, read from unit 65
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         for (int b = 0; b < 4; b++) nm[4*i+b] = r[8*b+:8];
         apb(1, 12'h010 + 4 * i, r);
      end
      for (int a = 2002; a <= 2009; a++) req(0, 0, 65, a, 0);
      $display("test name done");
      // producer side writes, the other side reads the same word
      foreach (aset[i]) begin
         t = i == 0 ? 1 : i == 1 ? 40 : i == 2 ? 65 : 66;
         req(t < 33 ? 0 : 1, 1, t, 4000, $urandom);
         req(t < 33 ? 1 : 0, 0, t, 4000, 0);
      end
      // random mixed traffic over both sides and edge ranges
      repeat (400)
         req($urandom % 2, $urandom % 2, $urandom % 68, aset[$urandom % 5],
             $urandom);
      $display("test traffic done");
      conclude();
   end
endmodule
